// file: hw/dum_top.v
// Dual serial channel pin block with AXI4-Lite control and interrupt
//
// Function
// R1 - With infrared select clear, each serial output idles high, also through reset.
// R2 - Infrared select moves that channel's output and input onto the infrared path.
// R3 - In infrared mode the serial output idles low.
// R4 - The far side keeps the standard serial input high while idle.
// R5 - Software asserts request-to-send before relying on automatic flow control.
// R6 - Clear-to-send is a plain input or the automatic transmit gate, chosen by two bits.
// R7 - Set-ready, carrier and ring inputs are status only and touch no data path.
// R8 - Output-2 bit set drives the interrupt pin and drives the output-2 pin low.
// R9 - Output-2 bit clear floats the interrupt pin and drives the output-2 pin high.
// R10 - A system using the interrupt pin should not use output-2 as a free output.
// R11 - Channel B receive-ready pin follows its receive buffer status.
// R12 - Request-to-send and terminal-ready are active low and usable as plain outputs.
// R13 - Channels A and B have separate, identical pin sets. Only channel B brings out a receive-ready pin; channel A's is left unconnected.
// R14 - Reset clears registers and outputs, holds serial out high and ignores serial in.
// R15 - Each modem output pin is the inverse of its control bit. Request-to-send is held high under automatic RTS while rx_fifo_full is set.
// R16 - Channel B receive-ready pin is low while data waits for the host.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dum_defines.vh"
module dum_top #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt
  output reg irq,
  // Channel A core side
  input wire tx_data_bit_a,
  input wire tx_busy_a,
  input wire ir_tx_bit_a,
  input wire rx_fifo_ready_a,
  input wire rx_fifo_full_a,
  input wire chan_irq_req_a,
  output wire rx_data_bit_a,
  output wire ir_rx_bit_a,
  output wire tx_allowed_a,
  // Channel B core side
  input wire tx_data_bit_b,
  input wire tx_busy_b,
  input wire ir_tx_bit_b,
  input wire rx_fifo_ready_b,
  input wire rx_fifo_full_b,
  input wire chan_irq_req_b,
  output wire rx_data_bit_b,
  output wire ir_rx_bit_b,
  output wire tx_allowed_b,
  // Channel A pins
  output wire serial_out_chan_a,
  input wire serial_in_chan_a,
  output wire request_to_send_n_a,
  input wire clear_to_send_n_a,
  output wire terminal_ready_n_a,
  input wire set_ready_n_a,
  input wire carrier_detect_n_a,
  input wire ring_indicator_n_a,
  output wire general_output_two_n_a,
  output wire interrupt_out_a,
  output wire interrupt_out_oe_a,
  // Channel B pins
  output wire serial_out_chan_b,
  input wire serial_in_chan_b,
  output wire request_to_send_n_b,
  input wire clear_to_send_n_b,
  output wire terminal_ready_n_b,
  input wire set_ready_n_b,
  input wire carrier_detect_n_b,
  input wire ring_indicator_n_b,
  output wire general_output_two_n_b,
  output wire interrupt_out_b,
  output wire interrupt_out_oe_b,
  output wire rx_ready_status_n
);
  reg [7:0] modem_control_reg_a_q;
  reg [7:0] modem_control_reg_b_q;
  reg [7:0] enhanced_feature_reg_a_q;
  reg [7:0] enhanced_feature_reg_b_q;
  reg [7:0] irq_enable_reg_a_q;
  reg [7:0] irq_enable_reg_b_q;
  reg [15:0] stat_q;
  reg [15:0] stat_d;
  reg [15:0] mask_q;
  reg [3:0] ms_a_prev_q;
  reg [3:0] ms_b_prev_q;
  reg rx_a_prev_q;
  reg rx_b_prev_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_d;
  wire [3:0] ms_a;
  wire [3:0] ms_b;
  wire [15:0] stat_set;
  wire [15:0] stat_clr;
  wire do_write;
  wire [7:0] wr_addr;
  wire [7:0] rd_addr;
  wire lane0;

  // Map hit test, shared by both channels of the bus
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `DUM_OFF_MCR_A, `DUM_OFF_MCR_B, `DUM_OFF_EFR_A, `DUM_OFF_EFR_B,
        `DUM_OFF_IER_A, `DUM_OFF_IER_B, `DUM_OFF_MSR, `DUM_OFF_STAT,
        `DUM_OFF_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] st;
    begin
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  assign wr_addr = awaddr_q[7:0];
  assign rd_addr = s_axi_araddr[7:0];
  assign lane0 = wstrb_q[0];
  // One write in flight; address and data may come in either order
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign do_write = aw_hold_q & w_hold_q;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DUM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? `DUM_RESP_OKAY : `DUM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; each byte sits in lane 0, the 16-bit mask in lanes 0 and 1
  always @(posedge aclk) begin
    if (!aresetn) begin
      modem_control_reg_a_q <= `DUM_CTRL_RST;
      modem_control_reg_b_q <= `DUM_CTRL_RST;
      enhanced_feature_reg_a_q <= `DUM_CTRL_RST;
      enhanced_feature_reg_b_q <= `DUM_CTRL_RST;
      irq_enable_reg_a_q <= `DUM_CTRL_RST;
      irq_enable_reg_b_q <= `DUM_CTRL_RST;
      mask_q <= `DUM_STAT_RST;
    end else if (do_write) begin
      case (wr_addr)
        `DUM_OFF_MCR_A: begin
          if (lane0) modem_control_reg_a_q <= wdata_q[7:0];
        end
        `DUM_OFF_MCR_B: begin
          if (lane0) modem_control_reg_b_q <= wdata_q[7:0];
        end
        `DUM_OFF_EFR_A: begin
          if (lane0) enhanced_feature_reg_a_q <= wdata_q[7:0];
        end
        `DUM_OFF_EFR_B: begin
          if (lane0) enhanced_feature_reg_b_q <= wdata_q[7:0];
        end
        `DUM_OFF_IER_A: begin
          if (lane0) irq_enable_reg_a_q <= wdata_q[7:0];
        end
        `DUM_OFF_IER_B: begin
          if (lane0) irq_enable_reg_b_q <= wdata_q[7:0];
        end
        `DUM_OFF_MASK: begin
          mask_q <= merge16(mask_q, wdata_q, wstrb_q);
        end
        default: begin
          mask_q <= mask_q;
        end
      endcase
    end
  end

  // Events: any modem input change, receive-ready rising
  assign stat_set[3:0] = ms_a ^ ms_a_prev_q;
  assign stat_set[`DUM_EV_RXRDY] = rx_fifo_ready_a & ~rx_a_prev_q;
  assign stat_set[`DUM_EV_B_LSB-1:`DUM_EV_RXRDY+1] = 3'b000;
  assign stat_set[`DUM_EV_B_LSB+3:`DUM_EV_B_LSB] = ms_b ^ ms_b_prev_q;
  assign stat_set[`DUM_EV_B_LSB+`DUM_EV_RXRDY] = rx_fifo_ready_b & ~rx_b_prev_q;
  assign stat_set[15:`DUM_EV_B_LSB+`DUM_EV_RXRDY+1] = 3'b000;
  assign stat_clr = (do_write && wr_addr == `DUM_OFF_STAT) ?
                    merge16(16'h0000, wdata_q, wstrb_q) : 16'h0000;

  always @* begin
    // Set beats a clear in the same cycle
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `DUM_STAT_RST;
      ms_a_prev_q <= 4'h0;
      ms_b_prev_q <= 4'h0;
      rx_a_prev_q <= 1'b0;
      rx_b_prev_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      ms_a_prev_q <= ms_a;
      ms_b_prev_q <= ms_b;
      rx_a_prev_q <= rx_fifo_ready_a;
      rx_b_prev_q <= rx_fifo_ready_b;
      irq <= |(stat_d & mask_q);
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    case (rd_addr)
      `DUM_OFF_MCR_A: rd_d[7:0] = modem_control_reg_a_q;
      `DUM_OFF_MCR_B: rd_d[7:0] = modem_control_reg_b_q;
      `DUM_OFF_EFR_A: rd_d[7:0] = enhanced_feature_reg_a_q;
      `DUM_OFF_EFR_B: rd_d[7:0] = enhanced_feature_reg_b_q;
      `DUM_OFF_IER_A: rd_d[7:0] = irq_enable_reg_a_q;
      `DUM_OFF_IER_B: rd_d[7:0] = irq_enable_reg_b_q;
      `DUM_OFF_MSR: rd_d[9:0] = {tx_allowed_b, tx_allowed_a, ms_b, ms_a};
      `DUM_OFF_STAT: rd_d[15:0] = stat_q;
      `DUM_OFF_MASK: rd_d[15:0] = mask_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DUM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= is_mapped(rd_addr) ? `DUM_RESP_OKAY : `DUM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // R13 two identical channels
  dum_chan u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .modem_control_reg(modem_control_reg_a_q),
    .enhanced_feature_reg(enhanced_feature_reg_a_q),
    .irq_enable_reg(irq_enable_reg_a_q),
    .tx_data_bit(tx_data_bit_a),
    .tx_busy(tx_busy_a),
    .ir_tx_bit(ir_tx_bit_a),
    .rx_fifo_ready(rx_fifo_ready_a),
    .rx_fifo_full(rx_fifo_full_a),
    .chan_irq_req(chan_irq_req_a),
    .rx_data_bit(rx_data_bit_a),
    .ir_rx_bit(ir_rx_bit_a),
    .tx_allowed(tx_allowed_a),
    .modem_status(ms_a),
    .serial_out(serial_out_chan_a),
    .serial_in(serial_in_chan_a),
    .request_to_send_n(request_to_send_n_a),
    .clear_to_send_n(clear_to_send_n_a),
    .terminal_ready_n(terminal_ready_n_a),
    .set_ready_n(set_ready_n_a),
    .carrier_detect_n(carrier_detect_n_a),
    .ring_indicator_n(ring_indicator_n_a),
    .general_output_two_n(general_output_two_n_a),
    .interrupt_out(interrupt_out_a),
    .interrupt_out_oe(interrupt_out_oe_a),
    .rx_ready_status_n()
  );

  dum_chan u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .modem_control_reg(modem_control_reg_b_q),
    .enhanced_feature_reg(enhanced_feature_reg_b_q),
    .irq_enable_reg(irq_enable_reg_b_q),
    .tx_data_bit(tx_data_bit_b),
    .tx_busy(tx_busy_b),
    .ir_tx_bit(ir_tx_bit_b),
    .rx_fifo_ready(rx_fifo_ready_b),
    .rx_fifo_full(rx_fifo_full_b),
    .chan_irq_req(chan_irq_req_b),
    .rx_data_bit(rx_data_bit_b),
    .ir_rx_bit(ir_rx_bit_b),
    .tx_allowed(tx_allowed_b),
    .modem_status(ms_b),
    .serial_out(serial_out_chan_b),
    .serial_in(serial_in_chan_b),
    .request_to_send_n(request_to_send_n_b),
    .clear_to_send_n(clear_to_send_n_b),
    .terminal_ready_n(terminal_ready_n_b),
    .set_ready_n(set_ready_n_b),
    .carrier_detect_n(carrier_detect_n_b),
    .ring_indicator_n(ring_indicator_n_b),
    .general_output_two_n(general_output_two_n_b),
    .interrupt_out(interrupt_out_b),
    .interrupt_out_oe(interrupt_out_oe_b),
    // R11 R16 channel B only
    .rx_ready_status_n(rx_ready_status_n)
  );
endmodule

// file: pkg/dum_defines.vh
// Register map, field positions and constants of the dual serial pin block
`ifndef DUM_DEFINES_VH
`define DUM_DEFINES_VH
`define DUM_OFF_MCR_A 8'h00
`define DUM_OFF_MCR_B 8'h04
`define DUM_OFF_EFR_A 8'h08
`define DUM_OFF_EFR_B 8'h0C
`define DUM_OFF_IER_A 8'h10
`define DUM_OFF_IER_B 8'h14
`define DUM_OFF_MSR 8'h18
`define DUM_OFF_STAT 8'h1C
`define DUM_OFF_MASK 8'h20
`define DUM_MCR_DTR 0
`define DUM_MCR_RTS 1
`define DUM_MCR_OP2 3
`define DUM_MCR_IR 6
`define DUM_EFR_AUTO_RTS 6
`define DUM_EFR_AUTO_CTS 7
`define DUM_IER_RTS 6
`define DUM_IER_CTS 7
`define DUM_CTRL_RST 8'h00
`define DUM_STAT_RST 16'h0000
`define DUM_SYNC_RST 5'h1F
`define DUM_EV_B_LSB 8
`define DUM_EV_RXRDY 4
`define DUM_RESP_OKAY 2'b00
`define DUM_RESP_SLVERR 2'b10
`define DUM_RST_MIN_NS 40
`define DUM_CLK_NS 5
`define DUM_RST_MIN_CYC ((`DUM_RST_MIN_NS + `DUM_CLK_NS - 1) / `DUM_CLK_NS)
`endif

// file: hw/dum_chan.v
// One serial channel: pin synchronisers, line muxing and modem pin drive
`timescale 1ns/1ps
`include "dum_defines.vh"
module dum_chan (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control registers
  input wire [7:0] modem_control_reg,
  input wire [7:0] enhanced_feature_reg,
  input wire [7:0] irq_enable_reg,
  // Core side
  input wire tx_data_bit,
  input wire tx_busy,
  input wire ir_tx_bit,
  input wire rx_fifo_ready,
  input wire rx_fifo_full,
  input wire chan_irq_req,
  output reg rx_data_bit,
  output reg ir_rx_bit,
  output wire tx_allowed,
  output wire [3:0] modem_status,
  // Pins
  output reg serial_out,
  input wire serial_in,
  output reg request_to_send_n,
  input wire clear_to_send_n,
  output reg terminal_ready_n,
  input wire set_ready_n,
  input wire carrier_detect_n,
  input wire ring_indicator_n,
  output reg general_output_two_n,
  output reg interrupt_out,
  output reg interrupt_out_oe,
  output reg rx_ready_status_n
);
  wire [4:0] pins_in;
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg [4:0] s3_q;
  reg [4:0] filt_q;
  wire [4:0] filt_d;
  wire ir_mode;
  wire auto_cts;
  wire auto_rts;

  assign pins_in = {serial_in, ring_indicator_n, carrier_detect_n, set_ready_n, clear_to_send_n};
  // Level moves only once stages two and three agree
  assign filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  // R7 status only
  assign modem_status = ~filt_q[3:0];
  assign ir_mode = modem_control_reg[`DUM_MCR_IR];
  // R6 cts mode select
  assign auto_cts = enhanced_feature_reg[`DUM_EFR_AUTO_CTS] & irq_enable_reg[`DUM_IER_CTS];
  assign tx_allowed = ~auto_cts | ~filt_q[0];
  assign auto_rts = enhanced_feature_reg[`DUM_EFR_AUTO_RTS] & irq_enable_reg[`DUM_IER_RTS];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= `DUM_SYNC_RST;
      s2_q <= `DUM_SYNC_RST;
      s3_q <= `DUM_SYNC_RST;
      filt_q <= `DUM_SYNC_RST;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  always @(posedge aclk) begin
    // R14 reset pin levels
    if (!aresetn) begin
      serial_out <= 1'b1;
      rx_data_bit <= 1'b1;
      ir_rx_bit <= 1'b0;
      request_to_send_n <= 1'b1;
      terminal_ready_n <= 1'b1;
      general_output_two_n <= 1'b1;
      interrupt_out <= 1'b0;
      interrupt_out_oe <= 1'b0;
      rx_ready_status_n <= 1'b1;
    end else begin
      // R1 R2 R3 line idle levels
      if (ir_mode) begin
        serial_out <= tx_busy & ir_tx_bit;
      end else begin
        serial_out <= ~tx_busy | tx_data_bit;
      end
      // R2 receive path select
      rx_data_bit <= ir_mode | filt_q[4];
      ir_rx_bit <= ir_mode & filt_q[4];
      // R12 R15 inverted pin drive
      request_to_send_n <= ~(modem_control_reg[`DUM_MCR_RTS] & ~(auto_rts & rx_fifo_full));
      terminal_ready_n <= ~modem_control_reg[`DUM_MCR_DTR];
      // R8 R9 op2 gates interrupt
      general_output_two_n <= ~modem_control_reg[`DUM_MCR_OP2];
      interrupt_out_oe <= modem_control_reg[`DUM_MCR_OP2];
      interrupt_out <= chan_irq_req;
      // R11 R16 receive ready pin
      rx_ready_status_n <= ~rx_fifo_ready;
    end
  end
endmodule

// file: verification/dum_line_model.sv
// Far-side serial device model: receive line and modem status pins
`timescale 1ns/1ps
module dum_line_model (
  // Clock
  input wire aclk,
  // Requests, active high: {ri, cd, dsr, cts, line low}
  input wire [4:0] req_a,
  input wire [4:0] req_b,
  // Pins as on the wire
  output reg [4:0] pins_a,
  output reg [4:0] pins_b
);
  initial begin
    pins_a = 5'h1F;
    pins_b = 5'h1F;
  end
  // idle line and status pins high
  always @(posedge aclk) begin
    pins_a <= ~req_a;
    pins_b <= ~req_b;
  end
endmodule

// file: verification/dum_top_props.sv
// Pin-level assertions for the dual serial pin block
`timescale 1ns/1ps
module dum_top_props (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Core side
  input wire chan_irq_req_a,
  input wire chan_irq_req_b,
  input wire rx_fifo_ready_b,
  // Pins
  input wire serial_out_chan_a,
  input wire serial_out_chan_b,
  input wire request_to_send_n_a,
  input wire terminal_ready_n_a,
  input wire general_output_two_n_a,
  input wire general_output_two_n_b,
  input wire interrupt_out_a,
  input wire interrupt_out_b,
  input wire interrupt_out_oe_a,
  input wire interrupt_out_oe_b,
  input wire rx_ready_status_n
);
  default clocking cb @(posedge aclk);
  endclocking
  chk_sout_reset: assert property (!aresetn |=> serial_out_chan_a && serial_out_chan_b)
    else $error("serial output not high in reset");
  chk_pins_reset: assert property (!aresetn |=> request_to_send_n_a && terminal_ready_n_a
    && !interrupt_out_oe_a && rx_ready_status_n)
    else $error("modem pins not parked in reset");
  chk_op2_pair_a: assert property (disable iff (!aresetn)
    general_output_two_n_a == !interrupt_out_oe_a)
    else $error("output two and irq enable disagree on A");
  chk_op2_pair_b: assert property (disable iff (!aresetn)
    general_output_two_n_b == !interrupt_out_oe_b)
    else $error("output two and irq enable disagree on B");
  chk_int_follow_a: assert property (disable iff (!aresetn)
    $past(aresetn) |-> interrupt_out_a == $past(chan_irq_req_a))
    else $error("interrupt pin A does not follow request");
  chk_int_follow_b: assert property (disable iff (!aresetn)
    $past(aresetn) |-> interrupt_out_b == $past(chan_irq_req_b))
    else $error("interrupt pin B does not follow request");
  chk_rxrdy_follow: assert property (disable iff (!aresetn)
    $past(aresetn) |-> rx_ready_status_n == !$past(rx_fifo_ready_b))
    else $error("receive ready pin wrong");
  chk_rxrdy_rise: assert property (disable iff (!aresetn)
    $rose(rx_fifo_ready_b) |=> $fell(rx_ready_status_n))
    else $error("receive ready pin missed new data");
  cover property (interrupt_out_oe_a && interrupt_out_a);
  cover property ($fell(rx_ready_status_n));
  cover property (!serial_out_chan_a);
endmodule
bind dum_top dum_top_props i_dum_top_props (
  .aclk, .aresetn, .chan_irq_req_a, .chan_irq_req_b, .rx_fifo_ready_b,
  .serial_out_chan_a, .serial_out_chan_b, .request_to_send_n_a, .terminal_ready_n_a,
  .general_output_two_n_a, .general_output_two_n_b, .interrupt_out_a, .interrupt_out_b,
  .interrupt_out_oe_a, .interrupt_out_oe_b, .rx_ready_status_n
);

// file: verification/tb_dual_uart_serial_modem_pins.sv
// Self-checking bench for the dual serial pin block
`timescale 1ns/1ps
module tb_dual_uart_serial_modem_pins;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic tx_data_bit_a = 1'b0, tx_busy_a = 1'b0, ir_tx_bit_a = 1'b0, chan_irq_req_a = 1'b0;
  logic tx_data_bit_b = 1'b0, tx_busy_b = 1'b0, ir_tx_bit_b = 1'b0, chan_irq_req_b = 1'b0;
  logic rx_fifo_ready_a = 1'b0, rx_fifo_full_a = 1'b0;
  logic rx_fifo_ready_b = 1'b0, rx_fifo_full_b = 1'b0;
  wire rx_data_bit_a, ir_rx_bit_a, tx_allowed_a, rx_data_bit_b, ir_rx_bit_b, tx_allowed_b;
  wire serial_out_chan_a, request_to_send_n_a, terminal_ready_n_a, general_output_two_n_a;
  wire interrupt_out_a, interrupt_out_oe_a, serial_in_chan_a, clear_to_send_n_a;
  wire set_ready_n_a, carrier_detect_n_a, ring_indicator_n_a;
  wire serial_out_chan_b, request_to_send_n_b, terminal_ready_n_b, general_output_two_n_b;
  wire interrupt_out_b, interrupt_out_oe_b, serial_in_chan_b, clear_to_send_n_b;
  wire set_ready_n_b, carrier_detect_n_b, ring_indicator_n_b, rx_ready_status_n;
  logic [4:0] req_a = 5'h01;
  logic [4:0] req_b = 5'h00;
  integer seed = 31;
  int miscompares = 0;
  int checked = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] va, vb;
  int i;

  dum_top i_dum_top (.*);
  dum_line_model i_dum_line_model (
    .aclk(aclk),
    .req_a(req_a),
    .req_b(req_b),
    .pins_a({ring_indicator_n_a, carrier_detect_n_a, set_ready_n_a, clear_to_send_n_a,
      serial_in_chan_a}),
    .pins_b({ring_indicator_n_b, carrier_detect_n_b, set_ready_n_b, clear_to_send_n_b,
      serial_in_chan_b})
  );

  always #2.5 aclk = ~aclk;

  task close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task tmo;
    miscompares++;
    $display("Error bus wait exp answer got timeout");
    close_out();
  endtask

  task cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  task cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Values settle between edges, so the negedge view is what the edge samples
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic ta, tr;
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_bus("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus("bresp", {bq.pop_front(), 32'h0}, {s_axi_bresp, 32'h0});
  end

  initial begin
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    cmp_pin("reset_high", 8'hFF, {serial_out_chan_a, serial_out_chan_b, rx_data_bit_a,
      request_to_send_n_a, request_to_send_n_b, terminal_ready_n_b, general_output_two_n_a,
      rx_ready_status_n});
    cmp_pin("reset_low", 8'h00, {5'h00, interrupt_out_oe_a, interrupt_out_oe_b, irq});
    @(posedge aclk);
    aresetn <= 1'b1;
    req_a <= 5'h00;
    for (i = 0; i < 10; i++)
      rd(8'(i * 4), i == 6 ? 34'h300 : (i == 9 ? {2'b10, 32'h0} : 34'h0));
    wr(8'h24, 32'h000000FF, 2'b10);
    va = 8'h00;
    vb = 8'h00;
    for (i = 0; i < 6; i++) begin
      if (i[0]) vb = 8'($random(seed)) & 8'h0B;
      else va = 8'($random(seed)) & 8'h0B;
      wr(i[0] ? 8'h04 : 8'h00, {24'h0, i[0] ? vb : va}, 2'b00);
      rd(i[0] ? 8'h04 : 8'h00, {26'h0, i[0] ? vb : va});
      cyc(1);
      cmp_pin("pins_a", {4'h0, ~va[1], ~va[0], ~va[3], va[3]}, {4'h0, request_to_send_n_a,
        terminal_ready_n_a, general_output_two_n_a, interrupt_out_oe_a});
      cmp_pin("pins_b", {4'h0, ~vb[1], ~vb[0], ~vb[3], vb[3]}, {4'h0, request_to_send_n_b,
        terminal_ready_n_b, general_output_two_n_b, interrupt_out_oe_b});
    end
    // output two left to interrupt gating
    wr(8'h00, 32'h08, 2'b00);
    wr(8'h04, 32'h08, 2'b00);
    for (i = 0; i < 16; i++) begin
      @(posedge aclk);
      {chan_irq_req_a, chan_irq_req_b, rx_fifo_ready_b} <= 3'($random(seed));
    end
    @(posedge aclk);
    rx_fifo_ready_b <= 1'b1;
    cyc(2);
    cmp_pin("rx_ready_n", 8'h00, {7'h0, rx_ready_status_n});
    @(posedge aclk);
    rx_fifo_ready_b <= 1'b0;
    rx_fifo_ready_a <= 1'b1;
    cyc(2);
    cmp_pin("rx_ready_n", 8'h01, {7'h0, rx_ready_status_n});
    wr(8'h00, 32'h00, 2'b00);
    cyc(2);
    cmp_pin("idle_std", 8'h01, {7'h0, serial_out_chan_a});
    wr(8'h00, 32'h40, 2'b00);
    cyc(2);
    cmp_pin("idle_ir", 8'h03, {5'h0, serial_out_chan_a, ir_rx_bit_a, rx_data_bit_a});
    @(posedge aclk);
    tx_busy_a <= 1'b1;
    ir_tx_bit_a <= 1'b1;
    cyc(2);
    cmp_pin("tx_ir", 8'h01, {7'h0, serial_out_chan_a});
    wr(8'h00, 32'h00, 2'b00);
    cyc(2);
    cmp_pin("tx_std", 8'h15, {2'h0, serial_out_chan_a, serial_out_chan_b, ir_rx_bit_a,
      rx_data_bit_a, ir_rx_bit_b, rx_data_bit_b});
    wr(8'h1C, 32'hFFFF, 2'b00);
    wr(8'h20, 32'h0006, 2'b00);
    wr(8'h08, 32'h80, 2'b00);
    wr(8'h10, 32'h80, 2'b00);
    cyc(2);
    cmp_pin("cts_gate", 8'h00, {6'h0, tx_allowed_a, irq});
    @(posedge aclk);
    req_a <= 5'h1E;
    cyc(8);
    cmp_pin("cts_open", 8'h07, {5'h0, tx_allowed_a, rx_data_bit_a, irq});
    rd(8'h18, 34'h30F);
    rd(8'h1C, 34'h00F);
    wr(8'h1C, 32'h0006, 2'b00);
    cyc(3);
    cmp_pin("irq_clr", 8'h00, {7'h0, irq});
    @(posedge aclk);
    // Line driven low too, so the standard receive path must pass a zero
    req_a <= 5'h1D;
    cyc(8);
    cmp_pin("cts_mask", 8'h00, {5'h0, tx_allowed_a, irq, rx_data_bit_a});
    rd(8'h1C, 34'h009);
    wr(8'h10, 32'h00, 2'b00);
    cyc(2);
    cmp_pin("cts_plain", 8'h01, {7'h0, tx_allowed_a});
    wr(8'h00, 32'h02, 2'b00);
    wr(8'h04, 32'h02, 2'b00);
    wr(8'h08, 32'h40, 2'b00);
    wr(8'h10, 32'h40, 2'b00);
    @(posedge aclk);
    rx_fifo_full_a <= 1'b1;
    rx_fifo_full_b <= 1'b1;
    cyc(2);
    cmp_pin("auto_rts", 8'h02, {6'h0, request_to_send_n_a, request_to_send_n_b});
    close_out();
  end
endmodule
